// ===== pkg/ipd_cfg.svh
// Field positions, widths and counts for the PLL divider core
`ifndef IPD_CFG_SVH
`define IPD_CFG_SVH
`define IPD_WORD_W 20
`define IPD_AUX_W 8
`define IPD_MAIN_W 9
`define IPD_REF_W 6
`define IPD_SWALLOW_W 4
`define IPD_PRESCALE_LO 10
`define IPD_PRESCALE_HI 11
`define IPD_AUX_FP_OUT 2
`define IPD_AUX_PWRDN 3
`define IPD_AUX_CONT_LOAD 4
`define IPD_AUX_MODSEL_OUT 5
`define IPD_AUX_FC_OUT 6
`define IPD_WORD_RST 20'h0_0000
`define IPD_AUX_RST 8'h00
`endif

// ===== pkg/ipd_pkg.sv
// Types shared by the PLL divider core
package ipd_pkg;
   typedef struct packed {
      logic [5:0] ref_div;
      logic [8:0] main_div;
      logic bypass;
      logic [3:0] swallow;
   } ipd_div_s;
   typedef struct packed {
      logic serial_clk;
      logic serial_in;
      logic load_strobe;
      logic aux_write_select;
   } ipd_ser_s;
   typedef struct packed {
      logic pump_up_n;
      logic pump_down_n;
      logic lock_filter_node;
      logic lock_indicator;
   } ipd_pd_s;
endpackage

// ===== hw/ipd_core.sv
// Integer-N PLL divider, serial programming and phase detector core
`timescale 1ns/1ps
`include "ipd_cfg.svh"

module ipd_core #(
   parameter int WORD_W = `IPD_WORD_W,
   parameter int AUX_W = `IPD_AUX_W,
   parameter int MAIN_W = `IPD_MAIN_W,
   parameter int REF_W = `IPD_REF_W,
   parameter int SWALLOW_W = `IPD_SWALLOW_W
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic vco_in,
   input wire logic ref_in,
   input wire ipd_pkg::ipd_ser_s ser_in,
   input wire logic register_bank_select,
   input wire logic aux_bits_gate,
   output ipd_pkg::ipd_pd_s pd_out,
   output logic test_out,
   output logic divided_vco,
   output logic comparison_clock
);
   import ipd_pkg::*;

   // Widths are fixed by the serial word layout and the packed types
   if (WORD_W != `IPD_WORD_W) begin : g_bad_word
      $error("WORD_W must equal the serial word length");
   end
   if (AUX_W != `IPD_AUX_W) begin : g_bad_aux
      $error("AUX_W must equal the aux byte length");
   end
   if (MAIN_W != `IPD_MAIN_W) begin : g_bad_main
      $error("MAIN_W must match the main count field");
   end
   if (REF_W != `IPD_REF_W) begin : g_bad_ref
      $error("REF_W must match the reference count field");
   end
   if (SWALLOW_W != `IPD_SWALLOW_W) begin : g_bad_swallow
      $error("SWALLOW_W must match the swallow count field");
   end

   localparam int NS = 4;
   localparam int PRE_LO_LAST = `IPD_PRESCALE_LO - 1;
   localparam int PRE_HI_LAST = `IPD_PRESCALE_HI - 1;

   // Three-stage samplers for the serial, VCO and reference pins; bank select and aux gate are used unsampled
   wire [NS-1:0] pin_raw = {ser_in.serial_clk, ser_in.serial_in, ser_in.load_strobe,
                            ser_in.aux_write_select};
   wire [NS-1:0] stable_lvl;
   logic [NS-1:0] prev_q;
   logic [2:0] vco_smp_q;
   logic [2:0] ref_smp_q;
   logic vco_lvl_q, ref_lvl_q;

   genvar gi;
   generate
      for (gi = 0; gi < NS; gi++) begin : g_smp
         logic [2:0] smp_q;
         logic lvl_q;
         always_ff @(posedge sys_clk) begin
            if (!rst_n) begin
               smp_q <= 3'h0;
               lvl_q <= 1'b0;
            end else if (clk_en) begin
               smp_q <= {smp_q[1:0], pin_raw[gi]};
               // Last two stages must agree before a level is taken
               if (smp_q[1] == smp_q[2]) begin
                  lvl_q <= smp_q[2];
               end
            end
         end
         assign stable_lvl[gi] = lvl_q;
      end
   endgenerate

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         prev_q <= 4'h0;
         vco_smp_q <= 3'h0;
         ref_smp_q <= 3'h0;
         vco_lvl_q <= 1'b0;
         ref_lvl_q <= 1'b0;
      end else if (clk_en) begin
         prev_q <= stable_lvl;
         vco_smp_q <= {vco_smp_q[1:0], vco_in};
         ref_smp_q <= {ref_smp_q[1:0], ref_in};
         if (vco_smp_q[1] == vco_smp_q[2]) begin
            vco_lvl_q <= vco_smp_q[2];
         end
         if (ref_smp_q[1] == ref_smp_q[2]) begin
            ref_lvl_q <= ref_smp_q[2];
         end
      end
   end

   // Rising edge of a level against its value one cycle earlier
   function automatic logic rose(input logic now_v, input logic was_v);
      return now_v & ~was_v;
   endfunction

   wire sclk_s = stable_lvl[3];
   wire sdat_s = stable_lvl[2];
   wire load_s = stable_lvl[1];
   wire auxw_s = stable_lvl[0];
   wire sclk_rise = rose(sclk_s, prev_q[3]);
   wire load_rise = rose(load_s, prev_q[1]);
   wire auxw_fall = ~auxw_s & prev_q[0];
   logic vco_lvl_p_q, ref_lvl_p_q;
   wire vco_rise = rose(vco_lvl_q, vco_lvl_p_q);
   wire ref_rise = rose(ref_lvl_q, ref_lvl_p_q);

   // Serial programming registers; never powered down
   logic [WORD_W-1:0] divider_setting_word_q;
   logic [WORD_W-1:0] secondary_word_q;
   logic [AUX_W-1:0] aux_shift_q;
   logic [AUX_W-1:0] auxiliary_control_byte_q;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         divider_setting_word_q <= `IPD_WORD_RST;
         secondary_word_q <= `IPD_WORD_RST;
         aux_shift_q <= `IPD_AUX_RST;
         auxiliary_control_byte_q <= `IPD_AUX_RST;
      end else if (clk_en) begin
         if (sclk_rise && !auxw_s && !load_s) begin
            divider_setting_word_q <= {divider_setting_word_q[`IPD_WORD_W-2:0], sdat_s};
         end
         if (sclk_rise && auxw_s && !load_s) begin
            // First bit in ends at bit 0, so bit n is the n-th bit sent
            aux_shift_q <= {sdat_s, aux_shift_q[AUX_W-1:1]};
         end
         if (load_rise) begin
            secondary_word_q <= divider_setting_word_q;
         end
         if (auxw_fall) begin
            auxiliary_control_byte_q <= aux_shift_q;
         end
      end
   end

   // Decode a word into its counter fields, first bit in at the top
   function automatic ipd_div_s ipd_unpack(input logic [19:0] w);
      ipd_div_s d;
      d.ref_div = {w[19:18], w[7:4]};
      d.main_div = {w[17:16], w[14:8]};
      d.bypass = w[15];
      d.swallow = w[3:0];
      return d;
   endfunction

   // A bank switch reaches the counters at their next reload point
   // Bank selection
   wire [19:0] sel_word = register_bank_select ? divider_setting_word_q : secondary_word_q;
   wire ipd_div_s sel_div = ipd_unpack(sel_word);

   wire [7:0] aux_eff = aux_bits_gate ? 8'h00 : auxiliary_control_byte_q;
   // Power down stops counters and detector; the serial port keeps running
   wire pwr_down = aux_eff[`IPD_AUX_PWRDN];
   // Continuous load holds the main and reference counters at zero; the prescaler keeps counting and R zero still passes the reference
   wire cont_load = aux_eff[`IPD_AUX_CONT_LOAD];
   wire run = clk_en & ~pwr_down;

   // Active settings and counters
   ipd_div_s act_q;
   logic [3:0] pre_cnt_q;
   logic [MAIN_W-1:0] main_cnt_q;
   logic [SWALLOW_W-1:0] sw_cnt_q;
   logic [REF_W-1:0] ref_cnt_q;
   logic fp_q, fc_q;

   // Modulus 11 while swallow count remains
   wire modulus_select = ~act_q.bypass & (sw_cnt_q != 4'h0);
   wire [3:0] pre_last = modulus_select ? 4'(PRE_HI_LAST) : 4'(PRE_LO_LAST);
   wire pre_tick = vco_rise & (act_q.bypass | (pre_cnt_q == pre_last));
   wire main_end = pre_tick & (main_cnt_q == act_q.main_div);
   wire ref_end = ref_rise & (ref_cnt_q == act_q.ref_div);
   // Reload points are main and reference cycle ends, every cycle under continuous load
   wire reload_main = cont_load | main_end;
   wire reload_ref = cont_load | ref_end;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         act_q <= '0;
         pre_cnt_q <= 4'h0;
         main_cnt_q <= 9'h000;
         sw_cnt_q <= 4'h0;
         ref_cnt_q <= 6'h00;
         fp_q <= 1'b0;
         fc_q <= 1'b0;
         vco_lvl_p_q <= 1'b0;
         ref_lvl_p_q <= 1'b0;
      end else if (run) begin
         vco_lvl_p_q <= vco_lvl_q;
         ref_lvl_p_q <= ref_lvl_q;
         if (reload_main) begin
            act_q.main_div <= sel_div.main_div;
            act_q.bypass <= sel_div.bypass;
            act_q.swallow <= sel_div.swallow;
         end
         if (reload_ref) begin
            act_q.ref_div <= sel_div.ref_div;
         end
         if (vco_rise) begin
            pre_cnt_q <= (act_q.bypass || pre_cnt_q == pre_last) ? 4'h0 : pre_cnt_q + 4'h1;
         end
         if (main_end || cont_load) begin
            main_cnt_q <= 9'h000;
            sw_cnt_q <= sel_div.swallow;
         end else if (pre_tick) begin
            main_cnt_q <= main_cnt_q + 9'h001;
            if (sw_cnt_q != 4'h0) begin
               sw_cnt_q <= sw_cnt_q - 4'h1;
            end
         end
         if (main_end) begin
            fp_q <= 1'b1;
         end else if (pre_tick) begin
            fp_q <= 1'b0;
         end
         if (ref_end || cont_load) begin
            ref_cnt_q <= 6'h00;
         end else if (ref_rise) begin
            ref_cnt_q <= ref_cnt_q + 6'h01;
         end
         if (ref_end) begin
            fc_q <= 1'b1;
         end else if (ref_rise) begin
            fc_q <= 1'b0;
         end
      end
   end

   // Pass-through follows the sampled level, so its duty is that of the pin
   // R zero passes reference through
   wire fc_sig = (act_q.ref_div == 6'h00) ? ref_lvl_q : fc_q;
   // Bypass with no prescaler: main output as computed
   wire fp_sig = fp_q;

   logic fp_p_q, fc_p_q, up_q, dn_q;
   wire fp_rise = rose(fp_sig, fp_p_q);
   wire fc_rise = rose(fc_sig, fc_p_q);
   // Coincident edges cancel, so both pumps never sit low together
   wire both = (up_q | fc_rise) & (dn_q | fp_rise);

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         fp_p_q <= 1'b0;
         fc_p_q <= 1'b0;
         up_q <= 1'b0;
         dn_q <= 1'b0;
      end else if (run) begin
         fp_p_q <= fp_sig;
         fc_p_q <= fc_sig;
         up_q <= both ? 1'b0 : (up_q | fc_rise);
         dn_q <= both ? 1'b0 : (dn_q | fp_rise);
      end else if (clk_en) begin
         up_q <= 1'b0;
         dn_q <= 1'b0;
      end
   end

   logic test_q;
   wire test_fp = aux_eff[`IPD_AUX_FP_OUT] & fp_sig;
   wire test_ms = aux_eff[`IPD_AUX_MODSEL_OUT] & modulus_select;
   wire test_fc = aux_eff[`IPD_AUX_FC_OUT] & fc_sig;
   wire test_d = test_fp | test_ms | test_fc;
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         test_q <= 1'b0;
      end else if (clk_en) begin
         test_q <= pwr_down ? 1'b0 : test_d;
      end
   end

   // Registered reference-side output, pass-through case included
   logic cmp_q;
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cmp_q <= 1'b0;
      end else if (clk_en) begin
         cmp_q <= fc_sig;
      end
   end

   assign pd_out.pump_up_n = ~up_q;
   assign pd_out.pump_down_n = ~dn_q;
   assign pd_out.lock_filter_node = ~(pd_out.pump_up_n & pd_out.pump_down_n);
   assign pd_out.lock_indicator = pd_out.pump_up_n & pd_out.pump_down_n;
   assign test_out = test_q;
   assign divided_vco = fp_q;
   assign comparison_clock = cmp_q;
endmodule // ipd_core

// ===== dv/ipd_core_monitor.sv
// Checker on the PLL divider core ports
`timescale 1ns/1ps
module ipd_core_monitor (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic aux_bits_gate,
   input wire ipd_pkg::ipd_pd_s pd_out,
   input wire logic test_out,
   input wire logic divided_vco,
   input wire logic comparison_clock
);
   import ipd_pkg::*;
   wire logic up_n = pd_out.pump_up_n;
   wire logic dn_n = pd_out.pump_down_n;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence fc_seen;
      comparison_clock || $past(comparison_clock);
   endsequence
   sequence fp_seen;
      divided_vco || $past(divided_vco);
   endsequence
   a_filter_nand: assert property (pd_out.lock_filter_node == !(up_n && dn_n))
      else $error("filter node not nand of pumps");
   a_lock_and: assert property (pd_out.lock_indicator == (up_n && dn_n))
      else $error("lock indicator not and of pumps");
   a_lock_tracks: assert property ($changed(pd_out.lock_indicator) |->
      $changed(up_n) || $changed(dn_n)) else $error("lock moved without pumps");
   a_up_after_fc: assert property ($fell(up_n) |-> fc_seen)
      else $error("up pulse without reference edge");
   a_dn_after_fp: assert property ($fell(dn_n) |-> fp_seen)
      else $error("down pulse without divided edge");
   a_pumps_release: assert property (!up_n && !dn_n |-> ##[1:2] (up_n || dn_n))
      else $error("both pumps held low");
   a_gate_mutes: assert property (aux_bits_gate [*4] |-> !test_out)
      else $error("test output active while gated");
   a_reset_idle: assert property ($rose(rst_n) |-> up_n && dn_n && !test_out)
      else $error("outputs not idle after reset");
endmodule // ipd_core_monitor
bind ipd_core ipd_core_monitor u_mon (.sys_clk(sys_clk), .rst_n(rst_n),
   .aux_bits_gate(aux_bits_gate), .pd_out(pd_out), .test_out(test_out),
   .divided_vco(divided_vco), .comparison_clock(comparison_clock));

// ===== dv/ipd_host_model.sv
// Host driving the four-wire serial programming port
`timescale 1ns/1ps
module ipd_host_model (
   input wire logic sys_clk,
   output ipd_pkg::ipd_ser_s ser
);
   import ipd_pkg::*;
   initial ser = '0;
   task automatic shift(input logic [19:0] v, input int n);
      @(posedge sys_clk);
      for (int i = n - 1; i >= 0; i--) begin
         ser.serial_clk <= 1'b0;
         ser.serial_in <= v[i];
         repeat (5) @(posedge sys_clk);
         ser.serial_clk <= 1'b1;
         repeat (5) @(posedge sys_clk);
      end
      ser.serial_clk <= 1'b0;
      ser.serial_in <= ~ser.serial_in;
   endtask
   task automatic load_word(input logic [19:0] w, input logic stb);
      shift(w, 20);
      repeat (5) @(posedge sys_clk);
      ser.load_strobe <= stb;
      repeat (5) @(posedge sys_clk);
      ser.load_strobe <= 1'b0;
      repeat (5) @(posedge sys_clk);
   endtask
   task automatic load_aux(input logic [7:0] b);
      logic [7:0] m;
      logic [7:0] r;
      m = b & 8'h7c;
      // Bit 0 goes out first
      for (int k = 0; k < 8; k++) begin
         r[k] = m[7 - k];
      end
      @(posedge sys_clk) ser.aux_write_select <= 1'b1;
      repeat (5) @(posedge sys_clk);
      shift({12'h000, r}, 8);
      repeat (5) @(posedge sys_clk);
      ser.aux_write_select <= 1'b0;
      repeat (5) @(posedge sys_clk);
   endtask
endmodule // ipd_host_model

// ===== dv/ipd_core_tb_top.sv
// Self-checking bench for the PLL divider core
`timescale 1ns/1ps
module ipd_core_tb_top;
   import ipd_pkg::*;
   logic sys_clk, rst_n, vco_in, ref_in, register_bank_select, aux_bits_gate;
   logic test_out, divided_vco, comparison_clock, dv_q, cc_q, to_q;
   ipd_ser_s ser;
   ipd_pd_s pd_out;
   int err_count = 0;
   int checks_done = 0;
   int cyc = 0;
   wire dv_rise = divided_vco & ~dv_q;
   wire cc_rise = comparison_clock & ~cc_q;
   wire to_rise = test_out & ~to_q;
   ipd_core uut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(1'b1), .vco_in(vco_in),
      .ref_in(ref_in), .ser_in(ser), .register_bank_select(register_bank_select),
      .aux_bits_gate(aux_bits_gate), .pd_out(pd_out), .test_out(test_out),
      .divided_vco(divided_vco), .comparison_clock(comparison_clock));
   ipd_host_model host (.sys_clk(sys_clk), .ser(ser));
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   // Vco input period 8 cycles, reference 10 cycles
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      vco_in <= (cyc % 8 < 4);
      ref_in <= (cyc % 10 < 5);
      dv_q <= divided_vco;
      cc_q <= comparison_clock;
      to_q <= test_out;
   end
   function automatic logic [19:0] word(input logic [5:0] r, input logic [8:0] m,
      input logic b, input logic [3:0] a);
      return {r[5:4], m[8:7], b, m[6:0], r[3:0], a};
   endfunction
   task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (exp !== got) begin
         err_count++;
         $display("BAD %s expected %0d seen %0d", nm, exp, got);
      end
   endtask
   task automatic period(input bit fc, input int exp);
      int n;
      for (int k = 0; k < 3; k++) begin
         n = 0;
         do begin
            @(posedge sys_clk);
            #1 n++;
         end while (!(fc ? cc_rise : dv_rise) && n < 5000);
      end
      check(fc ? "fc period" : "fp period", exp, n);
   endtask
   task automatic watch(input bit fp, output int c);
      c = 0;
      repeat (400) begin
         @(posedge sys_clk);
         #1 c += int'(fp ? dv_rise : to_rise);
      end
   endtask
   task automatic t_normal();
      host.load_word(word(6'h00, 9'h00e, 1'b0, 4'hf), 1'b1);
      period(0, 1320);
      period(1, 10);
      $display("normal done");
   endtask
   task automatic t_bypass();
      host.load_word(word(6'h03, 9'h001, 1'b1, 4'h0), 1'b1);
      period(0, 16);
      period(1, 40);
      $display("bypass done");
   endtask
   task automatic t_bank();
      host.load_word(word(6'h03, 9'h002, 1'b1, 4'h0), 1'b0);
      period(0, 16);
      @(posedge sys_clk) register_bank_select <= 1'b1;
      period(0, 24);
      @(posedge sys_clk) register_bank_select <= 1'b0;
      host.load_word(word(6'h03, 9'h002, 1'b1, 4'h0), 1'b1);
      period(0, 24);
      $display("bank done");
   endtask
   task automatic t_aux();
      int c;
      int sel[3];
      sel = '{2, 5, 6};
      host.load_word(word(6'h00, 9'h001, 1'b0, 4'h2), 1'b1);
      for (int i = 0; i < 3; i++) begin
         host.load_aux(8'h01 << sel[i]);
         @(posedge sys_clk) aux_bits_gate <= 1'b0;
         watch(0, c);
         check("test_out live", 1, int'(c > 0));
         @(posedge sys_clk) aux_bits_gate <= 1'b1;
         watch(0, c);
         check("test_out gated", 0, c);
      end
      $display("aux done");
   endtask
   task automatic t_pwrdn();
      int c;
      host.load_aux(8'h08);
      @(posedge sys_clk) aux_bits_gate <= 1'b0;
      repeat (20) @(posedge sys_clk);
      watch(1, c);
      check("fp while down", 0, c);
      host.load_word(word(6'h00, 9'h001, 1'b1, 4'h0), 1'b1);
      host.load_aux(8'h00);
      period(0, 16);
      $display("power down done");
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge sys_clk);
      err_count++;
      $display("BAD watchdog expected done seen hang");
      conclude();
   end
   initial begin
      rst_n = 1'b0;
      register_bank_select = 1'b0;
      aux_bits_gate = 1'b1;
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge sys_clk);
      t_normal();
      t_bypass();
      t_bank();
      t_aux();
      t_pwrdn();
      conclude();
   end
endmodule // ipd_core_tb_top
